// ---- design/sgcsf_map.vh ----
// register offsets, field positions, reset values and timing for sgcsf
`ifndef SGCSF_MAP_VH
`define SGCSF_MAP_VH

// ==========================================================
// byte offsets on the host register interface
`define SGCSF_OFF_GCTRL_A      12'h0ac
`define SGCSF_OFF_GCTRL_B      12'h0ae
`define SGCSF_OFF_SAF1_LOW     12'h0b0
`define SGCSF_OFF_SAF1_MID     12'h0b2
`define SGCSF_OFF_SAF1_HIGH    12'h0b4
`define SGCSF_OFF_SAF2_LOW     12'h0b6
`define SGCSF_OFF_SAF2_MID     12'h0b8
`define SGCSF_OFF_SAF2_HIGH    12'h0ba
`define SGCSF_OFF_RSVD_FIRST   12'h0bc
`define SGCSF_OFF_RSVD_LAST    12'h0c7

// ==========================================================
// switch_global_control_a fields
`define SGCSF_A_QMAP_HI        15
`define SGCSF_A_QMAP_LO        14
`define SGCSF_A_DYN_FLUSH      10
`define SGCSF_A_STA_FLUSH      9
`define SGCSF_A_TAIL_TAG       8
`define SGCSF_A_PAUSE_HI       7
`define SGCSF_A_PAUSE_LO       0
`define SGCSF_A_WMASK          16'hc7ff
`define SGCSF_A_RESET          16'h8000

// queue-mapping codes
`define SGCSF_QMAP_P3          2'h0
`define SGCSF_QMAP_P123_A      2'h1
`define SGCSF_QMAP_P23         2'h2
`define SGCSF_QMAP_P123_B      2'h3

// per-priority queue select, bit n is priority n (1 = queue 1)
`define SGCSF_QSEL_P3          4'h8
`define SGCSF_QSEL_P23         4'hc
`define SGCSF_QSEL_P123        4'he

// ==========================================================
// switch_global_control_b fields
`define SGCSF_B_INV_HI         10
`define SGCSF_B_INV_LO         8
`define SGCSF_B_PVID_HI        5
`define SGCSF_B_PVID_LO        0
`define SGCSF_B_WMASK          16'h07ff
`define SGCSF_B_RMASK          16'h073f
`define SGCSF_B_RESET          16'h0000

`define SGCSF_SAF_RESET        16'h0000

// ==========================================================
// timing: one pause-limit unit
`define SGCSF_PAUSE_UNIT_MS    160
`define SGCSF_CLK_MHZ          125
`define SGCSF_PAUSE_UNIT_CYC   (`SGCSF_PAUSE_UNIT_MS * 1000 * `SGCSF_CLK_MHZ)

`endif

// ---- design/sgcsf_flush_hs.v ----
// self-clearing flush request handshake with the table flush engine
`timescale 1ns/1ns

module sgcsf_flush_hs (
    core_clk,
    srst,
    start,
    done,
    busy
);
    input  wire core_clk;
    input  wire srst;
    input  wire start;
    input  wire done;
    output wire busy;

    reg         busy_ff;
    reg         nxt_busy;

    // ==========================================================
    // request state
    // a start in the same cycle as done wins, so a new request is kept
    always @* begin
        nxt_busy = busy_ff;
        if (done) begin
            nxt_busy = 1'b0;
        end
        if (start) begin
            nxt_busy = 1'b1;
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= nxt_busy;
        end
    end

    assign busy = busy_ff;

endmodule // sgcsf_flush_hs

// ---- design/sgcsf_unit_tick.v ----
// free tick generator marking one pause-limit time unit
`timescale 1ns/1ns

module sgcsf_unit_tick #(
    parameter PERIOD_CYC = 20000000
) (
    core_clk,
    srst,
    enable,
    tick
);
    input  wire core_clk;
    input  wire srst;
    input  wire enable;
    output wire tick;

    localparam [31:0] LAST = PERIOD_CYC - 1;

    reg  [31:0] cnt_ff;
    reg         tick_ff;

    // ==========================================================
    // counter restarts while disabled so the first unit is whole
    always @(posedge core_clk) begin
        if (srst || !enable) begin
            cnt_ff  <= 32'h0;
            tick_ff <= 1'b0;
        end else if (cnt_ff == LAST) begin
            cnt_ff  <= 32'h0;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + 32'h1;
            tick_ff <= 1'b0;
        end
    end

    assign tick = tick_ff;

endmodule // sgcsf_unit_tick

// ---- design/sgcsf_ctrl.v ----
// switch global control and source-address filter register bank
//
// Behaviour
// - qmap bits 15-14, reset 10: code 00 p3->q1, code 10 p2-3->q1
// - qmap codes 01 and 11 put priorities 1, 2, 3 in queue 1
// - bit 10 write one flushes dynamic table, clears itself when done
// - bit 9 enables static table flush for spanning tree use
// - bit 8 enables host port tail-tag mode, resets to zero
// - bits 7-0 pause-off limit in 160 ms units, zero disables
// - control b bits 10-8 pick ports for invalid-VID frames
// - control b bits 5-3 insert PVID: host->p2, host->p1, p2->host
// - control b bits 2-0 insert PVID: p2->p1, p1->host, p1->p2
// - filter address 1 is three 16-bit words, low least significant
// - filter address 2 is three 16-bit words, high most significant
`timescale 1ns/1ns
`include "sgcsf_map.vh"

module sgcsf_ctrl #(
    parameter PAUSE_UNIT_CYC = `SGCSF_PAUSE_UNIT_CYC
) (
    core_clk,
    srst,
    reg_addr,
    reg_wr,
    reg_rd,
    reg_be,
    reg_wdata,
    reg_rdata,
    prio_queue_sel,
    dyn_flush_req,
    dyn_flush_done,
    sta_flush_en,
    tail_tag_en,
    pause_limit_units,
    pause_limit_en,
    pause_unit_tick,
    inv_vid_fwd_ports,
    pvid_insert_en,
    saf_mac1,
    saf_mac2
);
    input  wire        core_clk;
    input  wire        srst;
    input  wire [11:0] reg_addr;
    input  wire        reg_wr;
    input  wire        reg_rd;
    input  wire [1:0]  reg_be;
    input  wire [15:0] reg_wdata;
    output wire [15:0] reg_rdata;
    output wire [3:0]  prio_queue_sel;
    output wire        dyn_flush_req;
    input  wire        dyn_flush_done;
    output wire        sta_flush_en;
    output wire        tail_tag_en;
    output wire [7:0]  pause_limit_units;
    output wire        pause_limit_en;
    output wire        pause_unit_tick;
    output wire [2:0]  inv_vid_fwd_ports;
    output wire [5:0]  pvid_insert_en;
    output wire [47:0] saf_mac1;
    output wire [47:0] saf_mac2;

    // ==========================================================
    // storage
    reg  [15:0] gctrl_a_ff;
    reg  [15:0] gctrl_b_ff;
    reg  [15:0] saf1_low_ff;
    reg  [15:0] saf1_mid_ff;
    reg  [15:0] saf1_high_ff;
    reg  [15:0] saf2_low_ff;
    reg  [15:0] saf2_mid_ff;
    reg  [15:0] saf2_high_ff;
    reg  [15:0] rdata_ff;
    reg  [3:0]  qsel_ff;

    reg  [15:0] nxt_rdata;
    reg  [3:0]  nxt_qsel;

    wire [15:0] lane_mask;
    wire        hit_a;
    wire        hit_b;
    wire        hit_s1l;
    wire        hit_s1m;
    wire        hit_s1h;
    wire        hit_s2l;
    wire        hit_s2m;
    wire        hit_s2h;
    wire        hit_rsvd;
    wire        flush_start;
    wire        flush_busy;
    wire [15:0] gctrl_a_view;

    // ==========================================================
    // address decode; the host bus addresses 16-bit words
    assign hit_a   = ({reg_addr[11:1], 1'b0} == `SGCSF_OFF_GCTRL_A);
    assign hit_b   = ({reg_addr[11:1], 1'b0} == `SGCSF_OFF_GCTRL_B);
    assign hit_s1l = ({reg_addr[11:1], 1'b0} == `SGCSF_OFF_SAF1_LOW);
    assign hit_s1m = ({reg_addr[11:1], 1'b0} == `SGCSF_OFF_SAF1_MID);
    assign hit_s1h = ({reg_addr[11:1], 1'b0} == `SGCSF_OFF_SAF1_HIGH);
    assign hit_s2l = ({reg_addr[11:1], 1'b0} == `SGCSF_OFF_SAF2_LOW);
    assign hit_s2m = ({reg_addr[11:1], 1'b0} == `SGCSF_OFF_SAF2_MID);
    assign hit_s2h = ({reg_addr[11:1], 1'b0} == `SGCSF_OFF_SAF2_HIGH);

    // reserved window holds nothing: writes dropped, reads zero
    assign hit_rsvd = (reg_addr >= `SGCSF_OFF_RSVD_FIRST) &&
                      (reg_addr <= `SGCSF_OFF_RSVD_LAST);

    // byte lanes: 8-bit hosts write one lane at a time
    assign lane_mask = {{8{reg_be[1]}}, {8{reg_be[0]}}};

    // ==========================================================
    // dynamic table flush: write one starts, done clears
    // learning is assumed already off on every port
    assign flush_start = reg_wr && hit_a && reg_be[1] &&
                         reg_wdata[`SGCSF_A_DYN_FLUSH];

    sgcsf_flush_hs u_flush (
        .core_clk (core_clk),
        .srst     (srst),
        .start    (flush_start),
        .done     (dyn_flush_done),
        .busy     (flush_busy)
    );

    // ==========================================================
    // global control a; bit 10 is held by the flush handshake
    always @(posedge core_clk) begin
        if (srst) begin
            gctrl_a_ff <= `SGCSF_A_RESET;
        end else if (reg_wr && hit_a) begin
            // reserved 13-11 and the self-clearing bit never store
            gctrl_a_ff <= (gctrl_a_ff & ~(lane_mask & `SGCSF_A_WMASK)) |
                          (reg_wdata & lane_mask & `SGCSF_A_WMASK &
                           ~(16'h1 << `SGCSF_A_DYN_FLUSH));
        end
    end

    assign gctrl_a_view = {gctrl_a_ff[15:11], flush_busy,
                           gctrl_a_ff[9:0]};

    // ==========================================================
    // global control b
    always @(posedge core_clk) begin
        if (srst) begin
            gctrl_b_ff <= `SGCSF_B_RESET;
        end else if (reg_wr && hit_b) begin
            // 15-11 ignore writes
            gctrl_b_ff <= (gctrl_b_ff & ~(lane_mask & `SGCSF_B_WMASK)) |
                          (reg_wdata & lane_mask & `SGCSF_B_WMASK);
        end
    end

    // ==========================================================
    // source filter address words
    always @(posedge core_clk) begin
        if (srst) begin
            saf1_low_ff  <= `SGCSF_SAF_RESET;
            saf1_mid_ff  <= `SGCSF_SAF_RESET;
            saf1_high_ff <= `SGCSF_SAF_RESET;
            saf2_low_ff  <= `SGCSF_SAF_RESET;
            saf2_mid_ff  <= `SGCSF_SAF_RESET;
            saf2_high_ff <= `SGCSF_SAF_RESET;
        end else if (reg_wr) begin
            if (hit_s1l) begin
                saf1_low_ff <= (saf1_low_ff & ~lane_mask) |
                               (reg_wdata & lane_mask);
            end
            if (hit_s1m) begin
                saf1_mid_ff <= (saf1_mid_ff & ~lane_mask) |
                               (reg_wdata & lane_mask);
            end
            if (hit_s1h) begin
                saf1_high_ff <= (saf1_high_ff & ~lane_mask) |
                                (reg_wdata & lane_mask);
            end
            if (hit_s2l) begin
                saf2_low_ff <= (saf2_low_ff & ~lane_mask) |
                               (reg_wdata & lane_mask);
            end
            if (hit_s2m) begin
                saf2_mid_ff <= (saf2_mid_ff & ~lane_mask) |
                               (reg_wdata & lane_mask);
            end
            if (hit_s2h) begin
                saf2_high_ff <= (saf2_high_ff & ~lane_mask) |
                                (reg_wdata & lane_mask);
            end
        end
    end

    // ==========================================================
    // read path; data appear the cycle after the strobe
    always @* begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            if (hit_a) begin
                nxt_rdata = gctrl_a_view;
            end else if (hit_b) begin
                nxt_rdata = gctrl_b_ff & `SGCSF_B_RMASK;
            end else if (hit_s1l) begin
                nxt_rdata = saf1_low_ff;
            end else if (hit_s1m) begin
                nxt_rdata = saf1_mid_ff;
            end else if (hit_s1h) begin
                nxt_rdata = saf1_high_ff;
            end else if (hit_s2l) begin
                nxt_rdata = saf2_low_ff;
            end else if (hit_s2m) begin
                nxt_rdata = saf2_mid_ff;
            end else if (hit_s2h) begin
                nxt_rdata = saf2_high_ff;
            end else if (hit_rsvd) begin
                nxt_rdata = 16'h0000;
            end else begin
                nxt_rdata = 16'h0000;
            end
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // ==========================================================
    // priority to egress queue mapping, two-queue configuration
    always @* begin
        case (gctrl_a_ff[`SGCSF_A_QMAP_HI:`SGCSF_A_QMAP_LO])
            `SGCSF_QMAP_P3: begin
                nxt_qsel = `SGCSF_QSEL_P3;
            end
            `SGCSF_QMAP_P23: begin
                nxt_qsel = `SGCSF_QSEL_P23;
            end
            `SGCSF_QMAP_P123_A: begin
                nxt_qsel = `SGCSF_QSEL_P123;
            end
            `SGCSF_QMAP_P123_B: begin
                nxt_qsel = `SGCSF_QSEL_P123;
            end
            default: begin
                nxt_qsel = `SGCSF_QSEL_P23;
            end
        endcase
    end

    // registered so the forwarding path sees a clean level
    always @(posedge core_clk) begin
        if (srst) begin
            qsel_ff <= `SGCSF_QSEL_P23;
        end else begin
            qsel_ff <= nxt_qsel;
        end
    end

    assign prio_queue_sel = qsel_ff;

    // ==========================================================
    // pause-off limit; the tick only runs while a limit is set
    assign pause_limit_units =
        gctrl_a_ff[`SGCSF_A_PAUSE_HI:`SGCSF_A_PAUSE_LO];
    assign pause_limit_en = |pause_limit_units;

    sgcsf_unit_tick #(
        .PERIOD_CYC (PAUSE_UNIT_CYC)
    ) u_tick (
        .core_clk (core_clk),
        .srst     (srst),
        .enable   (pause_limit_en),
        .tick     (pause_unit_tick)
    );

    // ==========================================================
    // control outputs
    assign dyn_flush_req = flush_busy;
    assign sta_flush_en  = gctrl_a_ff[`SGCSF_A_STA_FLUSH];
    assign tail_tag_en   = gctrl_a_ff[`SGCSF_A_TAIL_TAG];

    // bit 2 host port, bit 1 port 2, bit 0 port 1
    assign inv_vid_fwd_ports =
        gctrl_b_ff[`SGCSF_B_INV_HI:`SGCSF_B_INV_LO];

    // 5 host->p2, 4 host->p1, 3 p2->host
    // 2 p2->p1, 1 p1->host, 0 p1->p2
    assign pvid_insert_en =
        gctrl_b_ff[`SGCSF_B_PVID_HI:`SGCSF_B_PVID_LO];

    // low word is least significant
    assign saf_mac1 = {saf1_high_ff, saf1_mid_ff, saf1_low_ff};
    // high word is most significant
    assign saf_mac2 = {saf2_high_ff, saf2_mid_ff, saf2_low_ff};

endmodule // sgcsf_ctrl

// ---- verification/sgcsf_ctrl_checker.sv ----
// concurrent assertions watching the sgcsf_ctrl ports
`timescale 1ns/1ns

// ==========================================================
// checker
module sgcsf_ctrl_checker #(
    parameter PAUSE_UNIT_CYC = 8
) (
    input logic        core_clk,
    input logic        srst,
    input logic [11:0] reg_addr,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [1:0]  reg_be,
    input logic [15:0] reg_wdata,
    input logic [15:0] reg_rdata,
    input logic [3:0]  prio_queue_sel,
    input logic        dyn_flush_req,
    input logic        dyn_flush_done,
    input logic        tail_tag_en,
    input logic [7:0]  pause_limit_units,
    input logic        pause_limit_en,
    input logic        pause_unit_tick,
    input logic [2:0]  inv_vid_fwd_ports,
    input logic [5:0]  pvid_insert_en,
    input logic [47:0] saf_mac1
);
    logic        wa;
    logic        wb;
    logic [31:0] gap_ff;
    logic        seen_ff;

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    assign wa = reg_wr && reg_addr == 12'h0ac && reg_be[1];
    assign wb = reg_wr && reg_addr == 12'h0ae;

    // the first tick after enable follows no earlier tick, so only gaps between ticks count
    always @(posedge core_clk) begin
        if (srst || !pause_limit_en) begin
            gap_ff  <= 32'h0;
            seen_ff <= 1'b0;
        end else begin
            gap_ff  <= pause_unit_tick ? 32'h1 : gap_ff + 32'h1;
            seen_ff <= seen_ff | pause_unit_tick;
        end
    end

    a_qmap_p3: assert property (
        wa && reg_wdata[15:14] == 2'h0 |-> ##2 prio_queue_sel == 4'h8)
        else $error("queue map code 00 gave wrong selection");
    a_qmap_p123: assert property (
        wa && reg_wdata[14] |-> ##2 prio_queue_sel == 4'he)
        else $error("queue map odd code gave wrong selection");
    a_flush_set: assert property (
        wa && reg_wdata[10] |=> dyn_flush_req)
        else $error("flush request not raised");
    a_flush_hold: assert property (
        dyn_flush_req && !dyn_flush_done |=> dyn_flush_req)
        else $error("flush request dropped before done");
    a_flush_clear: assert property (
        dyn_flush_req && dyn_flush_done && !(wa && reg_wdata[10])
        |=> !dyn_flush_req)
        else $error("flush request not cleared by done");
    a_pause_en: assert property (
        pause_limit_en == (pause_limit_units != 8'h00))
        else $error("pause limit enable disagrees with units");
    a_tick_gap: assert property (
        pause_unit_tick && seen_ff |-> gap_ff == PAUSE_UNIT_CYC)
        else $error("pause unit tick spacing wrong");
    a_tail_tag: assert property (
        wa |=> tail_tag_en == $past(reg_wdata[8]))
        else $error("tail tag enable not written");
    a_inv_vid: assert property (
        wb && reg_be[1] |=> inv_vid_fwd_ports == $past(reg_wdata[10:8]))
        else $error("invalid vid ports not written");
    a_pvid_bits: assert property (
        wb && reg_be[0] |=> pvid_insert_en == $past(reg_wdata[5:0]))
        else $error("pvid insert bits not written");
    a_saf_low: assert property (
        reg_wr && reg_addr == 12'h0b0 && reg_be == 2'h3
        |=> saf_mac1[15:0] == $past(reg_wdata))
        else $error("filter address low word not written");
    a_rsvd_zero: assert property (
        reg_rd && reg_addr >= 12'h0bc && reg_addr <= 12'h0c7
        |=> reg_rdata == 16'h0000)
        else $error("reserved range read not zero");

    c_flush: cover property (dyn_flush_req && dyn_flush_done);
    c_tick: cover property (pause_unit_tick && seen_ff);
    c_rsvd: cover property (reg_rd && reg_addr == 12'h0bc);
endmodule // sgcsf_ctrl_checker

bind sgcsf_ctrl sgcsf_ctrl_checker #(
    .PAUSE_UNIT_CYC (PAUSE_UNIT_CYC)
) u_sgcsf_ctrl_checker (
    .core_clk          (core_clk),
    .srst              (srst),
    .reg_addr          (reg_addr),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_be            (reg_be),
    .reg_wdata         (reg_wdata),
    .reg_rdata         (reg_rdata),
    .prio_queue_sel    (prio_queue_sel),
    .dyn_flush_req     (dyn_flush_req),
    .dyn_flush_done    (dyn_flush_done),
    .tail_tag_en       (tail_tag_en),
    .pause_limit_units (pause_limit_units),
    .pause_limit_en    (pause_limit_en),
    .pause_unit_tick   (pause_unit_tick),
    .inv_vid_fwd_ports (inv_vid_fwd_ports),
    .pvid_insert_en    (pvid_insert_en),
    .saf_mac1          (saf_mac1)
);

// ---- verification/sgcsf_ctrl_test.sv ----
// self-checking bench for the sgcsf_ctrl register bank
`timescale 1ns/1ns

// ==========================================================
// signals and design
module sgcsf_ctrl_test;
    localparam int UNIT = 8;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [1:0]  reg_be = 2'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        dyn_flush_done = 1'b0;
    wire  [15:0] reg_rdata;
    wire  [3:0]  prio_queue_sel;
    wire         dyn_flush_req;
    wire         sta_flush_en;
    wire         tail_tag_en;
    wire  [7:0]  pause_limit_units;
    wire         pause_limit_en;
    wire         pause_unit_tick;
    wire  [2:0]  inv_vid_fwd_ports;
    wire  [5:0]  pvid_insert_en;
    wire  [47:0] saf_mac1;
    wire  [47:0] saf_mac2;
    int          error_cnt = 0;
    int          check_count = 0;
    logic [3:0]  qsel [4] = '{4'h8, 4'he, 4'hc, 4'he};

    // short unit keeps the run small; the gap check uses the same value
    sgcsf_ctrl #(
        .PAUSE_UNIT_CYC (UNIT)
    ) u_sgcsf_ctrl (
        .core_clk          (core_clk),
        .srst              (srst),
        .reg_addr          (reg_addr),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_be            (reg_be),
        .reg_wdata         (reg_wdata),
        .reg_rdata         (reg_rdata),
        .prio_queue_sel    (prio_queue_sel),
        .dyn_flush_req     (dyn_flush_req),
        .dyn_flush_done    (dyn_flush_done),
        .sta_flush_en      (sta_flush_en),
        .tail_tag_en       (tail_tag_en),
        .pause_limit_units (pause_limit_units),
        .pause_limit_en    (pause_limit_en),
        .pause_unit_tick   (pause_unit_tick),
        .inv_vid_fwd_ports (inv_vid_fwd_ports),
        .pvid_insert_en    (pvid_insert_en),
        .saf_mac1          (saf_mac1),
        .saf_mac2          (saf_mac2)
    );

    always #4 core_clk = ~core_clk;

// ==========================================================
// tasks
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task report_and_stop;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [1:0] be,
                      input logic [15:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_be = be;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        check(reg_rdata, exp);
    endtask

    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (pause_unit_tick !== 1'b1 && n < 100);
        if (n >= 100) begin
            error_cnt++;
            report_and_stop;
        end
    endtask

// ==========================================================
// sequence
    initial begin
        int          i;
        int          n;
        logic [15:0] q;
        repeat (3) @(negedge core_clk);
        srst = 1'b0;
        rd(12'h0ac, 16'h8000);
        check(prio_queue_sel, 4'hc);
        rd(12'h0ae, 16'h0000);
        for (i = 0; i < 6; i++)
            rd(12'(12'h0b0 + 2 * i), 16'h0000);
        for (i = 0; i < 4; i++) begin
            wr(12'h0ac, 2'h2, {i[1:0], 14'h0000});
            @(negedge core_clk);
            check(prio_queue_sel, qsel[i]);
        end
        // address learning is taken as off on all three ports
        wr(12'h0ac, 2'h3, 16'hffff);
        rd(12'h0ac, 16'hc7ff);
        check({sta_flush_en, tail_tag_en, pause_limit_en,
               pause_limit_units}, 11'h7ff);
        wr(12'h0ac, 2'h3, 16'h0000);
        rd(12'h0ac, 16'h0400);
        @(negedge core_clk);
        dyn_flush_done = 1'b1;
        @(negedge core_clk);
        dyn_flush_done = 1'b0;
        check(dyn_flush_req, 1'b0);
        check({sta_flush_en, tail_tag_en}, 2'h0);
        wr(12'h0ac, 2'h1, 16'hff01);
        rd(12'h0ac, 16'h0001);
        wait_tick(n);
        wait_tick(n);
        check(n, UNIT);
        wr(12'h0ac, 2'h1, 16'h0000);
        check(pause_limit_en, 1'b0);
        // reserved bits are set on every write and must always read back as zero
        for (i = 0; i < 11; i++) begin
            q = 16'h0001 << i;
            wr(12'h0ae, 2'h3, q | 16'hf8c0);
            rd(12'h0ae, q & 16'h073f);
            check({inv_vid_fwd_ports, pvid_insert_en},
                  {q[10:8], q[5:0]});
        end
        for (i = 0; i < 6; i++)
            wr(12'(12'h0b0 + 2 * i), 2'h3, 16'(16'h1111 * (i + 1)));
        check(saf_mac1, 48'h3333_2222_1111);
        check(saf_mac2, 48'h6666_5555_4444);
        wr(12'h0b0, 2'h2, 16'habcd);
        check(saf_mac1[15:0], 16'hab11);
        wr(12'h0bc, 2'h3, 16'hffff);
        wr(12'h0c6, 2'h3, 16'hffff);
        rd(12'h0bc, 16'h0000);
        rd(12'h0c6, 16'h0000);
        rd(12'h0ba, 16'h6666);
        rd(12'h0a0, 16'h0000);
        // flush start meets done in the same edge: the new request is kept
        dyn_flush_done = 1'b1;
        wr(12'h0ac, 2'h2, 16'h0400);
        dyn_flush_done = 1'b0;
        check(dyn_flush_req, 1'b1);
        // mid-run reset brings every register back to its default
        srst = 1'b1;
        @(negedge core_clk);
        srst = 1'b0;
        check(dyn_flush_req, 1'b0);
        check(saf_mac1 | saf_mac2, 48'h0);
        check(prio_queue_sel, 4'hc);
        rd(12'h0ac, 16'h8000);
        report_and_stop;
    end
endmodule // sgcsf_ctrl_test
